/* hdl/stx_pkg.sv */
/*
 * Constants for the 8b/10b transmit path: word layout, pacing and latency.
 * Assumes a single core clock; every other rate is derived from it.
 */
`default_nettype none
package stx_pkg;
    // ==========================================================
    // Word layout
    localparam int WORD_BITS     = 16;
    localparam int BYTE_BITS     = 8;
    localparam int CHAR_BITS     = 10;
    localparam int SER_BITS      = 20;
    localparam int LOW_BYTE_POS  = 0;
    localparam int HIGH_BYTE_POS = 8;
    localparam int LOW_CHAR_POS  = 0;
    localparam int HIGH_CHAR_POS = 10;
    // ==========================================================
    // Rates and latency
    localparam int BIT_CLK_MULT  = 10;
    localparam int BITS_PER_WORD = 2 * BIT_CLK_MULT;
    localparam int FIFO_DEPTH    = 8;
    localparam int LAT_BIT_TIMES = 36;
    // Counted from the pin edge, so the two synchroniser stages are part of it
    localparam int LAT_PIPE      = 6;
    localparam int LAT_WAIT      = LAT_BIT_TIMES - LAT_PIPE;
    // ==========================================================
    // Reset disparity and the K28 block code
    localparam logic RD_RESET    = 1'b0;
    localparam logic [4:0] K28_X = 5'h1C;
    // ==========================================================
    // Serializer states, Gray coded along idle, wait, run
    typedef enum logic [1:0] {
        STX_IDLE = 2'b00,
        STX_WAIT = 2'b01,
        STX_RUN  = 2'b11
    } stx_state_e;
endpackage
`default_nettype wire

/* hdl/stx_fifo.sv */
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`default_nettype none
module stx_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Drain side
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign in_ready_out  = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];
    assign do_wr         = in_valid_in && in_ready_out;
    assign do_rd         = out_valid_out && out_ready_in;

    // ==========================================================
    // Storage
    always_ff @(posedge core_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // ==========================================================
    // Pointers and occupancy
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* hdl/stx_tx_path.sv */
/*
 * 8b/10b transmit path: word capture, two encoders, FIFO, serializer.
 * Assumes the reference clock and word pins are asynchronous to core_clk_in
 * and that the reference rate is one twentieth of the core rate.
 */
//
// Behaviour
// RULE1 - A high low-byte K flag sends the low byte as a control character, else as data.
// RULE2 - A high high-byte K flag sends the high byte as a control character, else as data.
// RULE3 - The word and both K flags are captured on each rising reference clock edge.
// RULE4 - The far side supplies a continuous reference clock of 80 to 135 MHz.
// RULE5 - The far side holds word and flags stable around each rising reference edge.
// RULE6 - An internal bit clock at ten times the reference rate drives the serializer.
// RULE7 - One bit leaves on each edge of the bit clock, twenty bits per word.
// RULE8 - Each serialized word goes out bit zero first.
// RULE9 - Load to bit zero latency is fixed once running, within 34 to 38 bit times.
// RULE10 - The word splits into low and high bytes, each with its own encoder.
// RULE11 - Each encoder turns 8 bits into a 10-bit character, 20 bits per word.
// RULE12 - Encoding follows the standard 8b/10b code with running disparity.
// RULE13 - The low-byte character is sent before the high-byte character.
`default_nettype none
module stx_tx_path
    import stx_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_in,
    // Parallel transmit pins
    input  wire logic                 tx_reference_clock_in,
    input  wire logic [WORD_BITS-1:0] tx_parallel_word_in,
    input  wire logic                 tx_kflag_low_byte_in,
    input  wire logic                 tx_kflag_high_byte_in,
    // Serial side
    output logic                      tx_serial_out,
    output logic                      tx_bit_clock_out,
    output logic                      tx_ready_out
);
    // ==========================================================
    // 8b/10b encoding, output bit 0 is the first bit on the line
    function automatic logic [10:0] enc8b10b(input logic [7:0] b, input logic k,
                                             input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic [4:0] x;
        logic [2:0] y;
        logic       rd6;
        logic       k28;
        logic       alt7;
        logic [9:0] c;
        logic [9:0] r;
        x   = b[4:0];
        y   = b[7:5];
        k28 = k && (x == K28_X);
        case (x)
            5'h00: s6 = 6'b100111;  5'h01: s6 = 6'b011101;
            5'h02: s6 = 6'b101101;  5'h03: s6 = 6'b110001;
            5'h04: s6 = 6'b110101;  5'h05: s6 = 6'b101001;
            5'h06: s6 = 6'b011001;  5'h07: s6 = 6'b111000;
            5'h08: s6 = 6'b111001;  5'h09: s6 = 6'b100101;
            5'h0A: s6 = 6'b010101;  5'h0B: s6 = 6'b110100;
            5'h0C: s6 = 6'b001101;  5'h0D: s6 = 6'b101100;
            5'h0E: s6 = 6'b011100;  5'h0F: s6 = 6'b010111;
            5'h10: s6 = 6'b011011;  5'h11: s6 = 6'b100011;
            5'h12: s6 = 6'b010011;  5'h13: s6 = 6'b110010;
            5'h14: s6 = 6'b001011;  5'h15: s6 = 6'b101010;
            5'h16: s6 = 6'b011010;  5'h17: s6 = 6'b111010;
            5'h18: s6 = 6'b110011;  5'h19: s6 = 6'b100110;
            5'h1A: s6 = 6'b010110;  5'h1B: s6 = 6'b110110;
            5'h1C: s6 = 6'b001110;  5'h1D: s6 = 6'b101110;
            5'h1E: s6 = 6'b011110;  default: s6 = 6'b101011;
        endcase
        if (k28) begin
            s6 = 6'b001111;
        end
        // Unbalanced blocks and D.7 invert under positive disparity
        if (rd && (($countones(s6) != 3) || (x == 5'h07))) begin
            s6 = ~s6;
        end
        rd6 = rd ^ ($countones(s6) != 3);
        case (y)
            3'h0: s4 = 4'b1011;  3'h1: s4 = 4'b1001;
            3'h2: s4 = 4'b0101;  3'h3: s4 = 4'b1100;
            3'h4: s4 = 4'b1101;  3'h5: s4 = 4'b1010;
            3'h6: s4 = 4'b0110;  default: s4 = 4'b1110;
        endcase
        // Alternate x.7 avoids a run of five equal bits across the boundary
        alt7 = (y == 3'h7) && (k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14))
               || (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        if (alt7) begin
            s4 = 4'b0111;
        end
        if (rd6 && (($countones(s4) != 2) || (y == 3'h3))) begin
            s4 = ~s4;
        end
        if (k28 && !rd6 && ($countones(s4) == 2) && (y != 3'h3)) begin
            s4 = ~s4;
        end
        c = {s6, s4};
        // Reverse in its own statement; a stream cannot sit inside a concatenation
        r = {<<{c}};
        return {rd6 ^ ($countones(s4) != 2), r}; // RULE8
    endfunction

    // ==========================================================
    // Pin synchronisers; the second stage is the only reader of the first
    logic                 ref_s1;
    logic                 ref_s2;
    logic                 ref_s3;
    logic [WORD_BITS+1:0] pin_s1;
    logic [WORD_BITS+1:0] pin_s2;

    always_ff @(posedge core_clk_in) begin
        ref_s1 <= tx_reference_clock_in;
        ref_s2 <= ref_s1;
        ref_s3 <= ref_s2;
        pin_s1 <= {tx_kflag_high_byte_in, tx_kflag_low_byte_in, tx_parallel_word_in};
        pin_s2 <= pin_s1;
    end

    // ==========================================================
    // Capture on the rising reference edge
    logic                 cap_valid;
    logic [WORD_BITS-1:0] cap_word;
    logic                 cap_k_low;
    logic                 cap_k_high;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cap_valid  <= 1'b0;
            cap_word   <= '0;
            cap_k_low  <= 1'b0;
            cap_k_high <= 1'b0;
        end else begin
            cap_valid <= ref_s2 && !ref_s3; // RULE3
            if (ref_s2 && !ref_s3) begin
                cap_word   <= pin_s2[WORD_BITS-1:0]; // RULE3
                cap_k_low  <= pin_s2[WORD_BITS];
                cap_k_high <= pin_s2[WORD_BITS+1];
            end
        end
    end

    // ==========================================================
    // Two encoders chained through one running disparity
    logic [10:0]         enc_low;
    logic [10:0]         enc_high;
    logic                run_disp;
    logic                enc_valid;
    logic [SER_BITS-1:0] enc_word;
    logic                fifo_in_ready;

    // RULE10 RULE11 RULE12
    assign enc_low  = enc8b10b(cap_word[LOW_BYTE_POS +: BYTE_BITS], cap_k_low, run_disp); // RULE1
    assign enc_high = enc8b10b(cap_word[HIGH_BYTE_POS +: BYTE_BITS], cap_k_high,
                               enc_low[CHAR_BITS]); // RULE2

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            run_disp  <= RD_RESET;
            enc_valid <= 1'b0;
            enc_word  <= '0;
        end else begin
            // A word arriving into a full FIFO is dropped, disparity left untouched
            enc_valid <= cap_valid && fifo_in_ready;
            if (cap_valid && fifo_in_ready) begin
                run_disp <= enc_high[CHAR_BITS]; // RULE12
                enc_word <= {enc_high[CHAR_BITS-1:0], enc_low[CHAR_BITS-1:0]}; // RULE13
            end
        end
    end

    // ==========================================================
    // Word buffer between encoder and serializer
    logic                fifo_out_valid;
    logic [SER_BITS-1:0] fifo_out_data;
    logic                fifo_pop;

    stx_fifo #(
        .WIDTH (SER_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (enc_valid),
        .in_data_in    (enc_word),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (fifo_out_valid),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (fifo_pop)
    );

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tx_ready_out <= 1'b0;
        end else begin
            tx_ready_out <= fifo_in_ready;
        end
    end

    // ==========================================================
    // Bit clock: toggles each core cycle, so every rising core edge is one bit-clock edge
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tx_bit_clock_out <= 1'b0;
        end else begin
            tx_bit_clock_out <= !tx_bit_clock_out; // RULE6
        end
    end

    // ==========================================================
    // Serializer; the start wait fixes the latency for the whole stream
    stx_state_e          state;
    logic [5:0]          wait_cnt;
    logic [4:0]          bit_cnt;
    logic [SER_BITS-1:0] shift;

    assign fifo_pop = fifo_out_valid && (((state == STX_WAIT) && (wait_cnt == '0))
                      || ((state == STX_RUN) && (bit_cnt == 5'(BITS_PER_WORD - 1))));

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state    <= STX_IDLE;
            wait_cnt <= '0;
            bit_cnt  <= '0;
        end else begin
            case (state)
                STX_IDLE: begin
                    if (fifo_out_valid) begin
                        state    <= STX_WAIT;
                        wait_cnt <= 6'(LAT_WAIT); // RULE9
                    end
                end
                STX_WAIT: begin
                    if (wait_cnt != '0) begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end else begin
                        state   <= STX_RUN;
                        bit_cnt <= '0;
                    end
                end
                STX_RUN: begin
                    if (bit_cnt != 5'(BITS_PER_WORD - 1)) begin
                        bit_cnt <= bit_cnt + 1'b1; // RULE7
                    end else if (fifo_pop) begin
                        bit_cnt <= '0;
                    end else begin
                        // Underrun: drop back and realign latency on the next word
                        state <= STX_IDLE;
                    end
                end
                default: begin
                    state <= STX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            shift         <= '0;
            tx_serial_out <= 1'b0;
        end else if (fifo_pop) begin
            shift         <= fifo_out_data >> 1;
            tx_serial_out <= fifo_out_data[0]; // RULE8
        end else if (state == STX_RUN) begin
            shift         <= shift >> 1; // RULE7 RULE13
            tx_serial_out <= shift[0];
        end else begin
            tx_serial_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* testbench/stx_tx_path_assertions.sv */
/*
 * Checker for the 8b/10b transmit path, bound to the top ports.
 * Assumes the far side paces one word per 20 core cycles.
 */
`default_nettype none
module stx_tx_path_chk
    import stx_pkg::*;
(
    input wire logic                 core_clk_in,
    input wire logic                 rst_in,
    input wire logic                 tx_reference_clock_in,
    input wire logic [WORD_BITS-1:0] tx_parallel_word_in,
    input wire logic                 tx_kflag_low_byte_in,
    input wire logic                 tx_kflag_high_byte_in,
    input wire logic                 tx_serial_out,
    input wire logic                 tx_bit_clock_out,
    input wire logic                 tx_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_q;
    logic [5:0] gap;
    logic [5:0] zrun;
    logic       rise;
    logic       quiet;
    // ====
    // Helpers: quiet means no word in flight, so latency starts clean
    assign rise  = tx_reference_clock_in && !ref_q;
    assign quiet = gap >= 6'h28 && zrun >= 6'h28;
    always_ff @(posedge core_clk_in) ref_q <= tx_reference_clock_in;
    always_ff @(posedge core_clk_in) begin
        if (rst_in || rise)
            gap <= 6'h00;
        else if (gap != 6'h3F)
            gap <= gap + 6'h01;
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in || tx_serial_out)
            zrun <= 6'h00;
        else if (zrun != 6'h3F)
            zrun <= zrun + 6'h01;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // ====
    // Properties
    property p_rst_idle;
        disable iff (1'b0) rst_in |=> !tx_serial_out && !tx_bit_clock_out;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("line not idle in reset");
    property p_bclk;
        !$past(rst_in) && !$past(rst_in, 2) |-> tx_bit_clock_out != $past(tx_bit_clock_out);
    endproperty
    a_bclk: assert property (p_bclk) else $error("bit clock missed a toggle");
    property p_ones;
        tx_serial_out [*5] |=> !tx_serial_out;
    endproperty
    a_ones: assert property (p_ones) else $error("run of ones too long");
    property p_zeros;
        gap < 6'h0A && tx_serial_out ##1 !tx_serial_out [*5] |=> tx_serial_out;
    endproperty
    a_zeros: assert property (p_zeros) else $error("run of zeros too long");
    property p_lat_min;
        quiet && rise |-> !tx_serial_out throughout (##34 1'b1);
    endproperty
    a_lat_min: assert property (p_lat_min) else $error("word left too early");
    property p_lat_max;
        quiet && rise |-> ##[35:41] tx_serial_out;
    endproperty
    a_lat_max: assert property (p_lat_max) else $error("word left too late");
    property p_rdy_up;
        $fell(rst_in) |-> ##2 tx_ready_out;
    endproperty
    a_rdy_up: assert property (p_rdy_up) else $error("ready late after reset");
    property p_rdy_hold;
        !$past(rst_in) && !$past(rst_in, 2) |-> tx_ready_out;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold) else $error("ready dropped at word rate");
endmodule
bind stx_tx_path stx_tx_path_chk u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .tx_reference_clock_in(tx_reference_clock_in), .tx_parallel_word_in(tx_parallel_word_in),
    .tx_kflag_low_byte_in(tx_kflag_low_byte_in), .tx_kflag_high_byte_in(tx_kflag_high_byte_in),
    .tx_serial_out(tx_serial_out), .tx_bit_clock_out(tx_bit_clock_out),
    .tx_ready_out(tx_ready_out));
`default_nettype wire

/* testbench/stx_proto_dev.sv */
/*
 * Protocol device model: pacing reference clock, word and K flags.
 * Assumes a core clock twenty times the reference rate.
 */
`default_nettype none
module stx_proto_dev (
    // Pacing
    input  wire logic clk_in,
    input  wire logic en_in,
    // Transmit bus
    output logic        ref_out,
    output logic [15:0] word_out,
    output logic        klo_out,
    output logic        khi_out,
    output logic        new_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 3547;
    int ph   = 0;
    int n    = 0;
    // ====
    // K flags only on K28 bytes; other K bytes have no defined code
    task automatic pick;
        word_out = 16'($random(seed));
        klo_out  = ($random(seed) % 3) == 0;
        khi_out  = ($random(seed) % 3) == 0;
        if (n < 8) begin
            {klo_out, khi_out} = 2'h3;
            word_out = {3'(7 - n), 5'h1C, 3'(n), 5'h1C};
        end
        if (klo_out)
            word_out[4:0] = 5'h1C;
        if (khi_out)
            word_out[12:8] = 5'h1C;
        n++;
    endtask
    initial begin
        ref_out = 1'b0;
        new_out = 1'b0;
        pick();
    end
    // A period always completes, so the clock never stops mid-cycle
    always @(negedge clk_in) begin
        new_out = 1'b0;
        if (en_in || ph != 0) begin
            if (ph == 0) begin
                ref_out = 1'b1;
                new_out = 1'b1;
            end
            if (ph == 10) begin
                ref_out = 1'b0;
                pick();
            end
            ph = (ph + 1) % 20;
        end
    end
endmodule
`default_nettype wire

/* testbench/stx_tx_path_tb.sv */
/*
 * Self-checking bench for the 8b/10b transmit path.
 * Assumes the partner model paces words; frames are matched on the line.
 */
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module stx_tx_path_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import stx_pkg::*;
    localparam logic [5:0] T6[32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19,
        6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23,
        6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E,
        6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] T4[8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    logic        core_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        en = 1'b0;
    logic        ref_clk;
    logic [15:0] word;
    logic        klo;
    logic        khi;
    logic        nw;
    logic        ser;
    logic        rdy;
    logic        done = 1'b0;
    logic        rd = 1'b0;
    logic [19:0] sh = 20'h00000;
    logic [19:0] exp_q[$];
    int          n_fail = 0;
    int          n_tests = 0;
    always #50 core_clk_in = ~core_clk_in;
    stx_proto_dev u_dev (.clk_in(core_clk_in), .en_in(en), .ref_out(ref_clk),
        .word_out(word), .klo_out(klo), .khi_out(khi), .new_out(nw));
    stx_tx_path DUT (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .tx_reference_clock_in(ref_clk), .tx_parallel_word_in(word),
        .tx_kflag_low_byte_in(klo), .tx_kflag_high_byte_in(khi),
        .tx_serial_out(ser), .tx_bit_clock_out(), .tx_ready_out(rdy));
    // ====
    // Reference encoder, one character at a time, carrying disparity
    function automatic logic [9:0] enc(input logic [7:0] b, input logic k);
        logic [5:0] s;
        logic [3:0] f;
        logic [4:0] x;
        logic [2:0] y;
        x = b[4:0];
        y = b[7:5];
        s = k ? 6'h0F : T6[x];
        f = T4[y];
        if ($countones(s) != 3 || x == 5'h07)
            s = rd ? ~s : s;
        rd = ($countones(s) != 3) ? ~rd : rd;
        if (y == 3'h7 && (k || (!rd && (x == 5'h11 || x == 5'h12 || x == 5'h14))
            || (rd && (x == 5'h0B || x == 5'h0D || x == 5'h0E))))
            f = 4'h7;
        if (k && !rd && (y == 3'h1 || y == 3'h2 || y == 3'h5 || y == 3'h6))
            f = ~f;
        if ($countones(f) != 2 || y == 3'h3)
            f = rd ? ~f : f;
        rd = ($countones(f) != 2) ? ~rd : rd;
        return {s, f};
    endfunction
    always @(posedge core_clk_in) begin : push
        logic [9:0] lo;
        logic [9:0] hi;
        if (nw === 1'b1) begin
            lo = enc(word[7:0], klo);
            hi = enc(word[15:8], khi);
            exp_q.push_back({lo, hi});
        end
    end
    // ====
    // Line watcher: lock on the first frame, then expect back to back frames
    initial begin : watch
        int k;
        logic [19:0] e;
        k = 0;
        while (nw !== 1'b1 && k < 500) begin @(posedge core_clk_in); k++; end
        k = 0;
        while (k < 60 && !(k >= 54 && exp_q.size() > 0 && sh === exp_q[0])) begin
            @(negedge core_clk_in);
            sh = {sh[18:0], ser};
            k++;
        end
        `CHK(k >= 54 && k <= 57, 1'b1)
        k = 0;
        while (exp_q.size() > 0 && k < 200) begin
            e = exp_q.pop_front();
            `CHK(sh, e)
            repeat (20) begin @(negedge core_clk_in); sh = {sh[18:0], ser}; end
            k++;
        end
        if (k >= 200)
            n_fail++;
        done = 1'b1;
    end
    task automatic finish_test;
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin : main
        int t;
        repeat (2) @(negedge core_clk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        `CHK(rdy, 1'b1)
        repeat (45) @(negedge core_clk_in);
        en = 1'b1;
        repeat (960) @(negedge core_clk_in);
        en = 1'b0;
        t = 0;
        while (!done && t < 400) begin @(negedge core_clk_in); t++; end
        if (!done)
            n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
